/* hdl/adsr_readout.sv */
// Serial conversion control and result readout of the sampling converter
// Contract
// - Trigger rise starts; ignore rises for 14 clocks
// - Only trigger rising edge matters
// - Each shift rise during a conversion advances, updates output
// - Second shift rise outputs settled flag
// - Then twelve result bits, MSB first
// - Output bit stable at next rise
// - Output high impedance from power-up
// - High impedance until first trigger rise
// - Valid bit by following shift rise
// - Two trigger rises without shift: light sleep
// - Four trigger rises: deep sleep, flag low
// - Shift rise wakes from power-down
// - Bipolar two's complement, unipolar binary
`timescale 1ns/1ps
`default_nettype none
module adsr_readout #(
    parameter int RESULT_BITS = adsr_pkg::RESULT_BITS,
    parameter int SETTLE_CYCLES = adsr_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Serial port pins
    input wire adsr_pkg::adsr_pins_type pins,
    output adsr_pkg::adsr_out_type result_out,
    // Converter core
    input wire logic [RESULT_BITS-1:0] sample_code,
    input wire logic bipolar_mode,
    // Power state
    output adsr_pkg::adsr_power_type power_state
);
    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic trig_rise;
    logic sck_rise;

    adsr_pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .pin({pins.trigger, pins.shift_clock}),
        .level(pin_level),
        .rise(pin_rise)
    );

    assign trig_rise = pin_rise[1];
    assign sck_rise = pin_rise[0];

    typedef struct packed {
        logic busy;
        logic [4:0] step;
        logic [2:0] idle_trigs;
        adsr_pkg::adsr_power_type power;
        logic settled;
        logic [31:0] settle_count;
        logic [RESULT_BITS-1:0] word;
        logic data;
        logic enable;
    } adsr_state_type;

    adsr_state_type state;
    adsr_state_type next_state;

    localparam logic [4:0] LAST_STEP = 5'(adsr_pkg::IGNORE_SCK_CYCLES);
    localparam logic [4:0] FLAG_STEP = 5'(adsr_pkg::FLAG_EDGE);
    localparam logic [4:0] DATA_END = 5'(adsr_pkg::FLAG_EDGE + RESULT_BITS);

    always_comb begin
        next_state = state;
        if (sck_rise) begin
            next_state.idle_trigs = '0;
            if (state.power != adsr_pkg::ADSR_ACTIVE) begin
                next_state.power = adsr_pkg::ADSR_ACTIVE;
            end
        end
        // Reference recount starts only once woken from deep power-down
        if (!state.settled && state.power != adsr_pkg::ADSR_DEEP_DOWN) begin
            if (state.settle_count >= 32'(SETTLE_CYCLES - 1)) begin
                next_state.settled = 1'b1;
            end else begin
                next_state.settle_count = state.settle_count + 32'h0000_0001;
            end
        end
        if (trig_rise && !sck_rise) begin
            if (state.idle_trigs != 3'h7) begin
                next_state.idle_trigs = state.idle_trigs + 3'h1;
            end
            if (state.idle_trigs + 3'h1 >= 3'(adsr_pkg::DEEP_DOWN_EDGES)) begin
                next_state.power = adsr_pkg::ADSR_DEEP_DOWN;
                next_state.settled = 1'b0;
                next_state.settle_count = '0;
            end else if (state.idle_trigs + 3'h1 >= 3'(adsr_pkg::LIGHT_DOWN_EDGES)) begin
                next_state.power = adsr_pkg::ADSR_LIGHT_DOWN;
            end
        end
        if (trig_rise && !state.busy) begin
            next_state.busy = 1'b1;
            next_state.step = 5'(adsr_pkg::STEP_RESET);
            next_state.enable = 1'b1;
            next_state.word = bipolar_mode ? {~sample_code[RESULT_BITS-1], sample_code[RESULT_BITS-2:0]}
                : sample_code;
        end else if (sck_rise && state.busy) begin
            next_state.step = state.step + 5'h01;
            if (state.step + 5'h01 == FLAG_STEP) begin
                next_state.data = state.settled;
            end else if (state.step + 5'h01 > FLAG_STEP && state.step + 5'h01 <= DATA_END) begin
                next_state.data = state.word[RESULT_BITS-1];
                next_state.word = {state.word[RESULT_BITS-2:0], 1'b0};
            end else begin
                next_state.data = 1'b0;
            end
            if (state.step + 5'h01 >= LAST_STEP) begin
                next_state.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Registered pin drive, stable until the next shift rise
    assign result_out.data = state.data;
    assign result_out.enable = state.enable;
    assign power_state = state.power;

    a_output_hiz_reset: assert property (@(posedge clock) disable iff (!rst_b)
        !state.enable && !trig_rise |=> !state.enable || state.busy)
        else $error("output enabled without trigger");
    a_flag_on_second: assert property (@(posedge clock) disable iff (!rst_b)
        state.busy && sck_rise && state.step == 5'h01 |=> result_out.data == $past(state.settled))
        else $error("flag bit not presented on second shift rise");
    a_step_advance: assert property (@(posedge clock) disable iff (!rst_b)
        state.busy && sck_rise && !trig_rise && state.step < 5'h0d |=> state.step == $past(state.step) + 5'h01)
        else $error("shift rise did not advance");
    a_trigger_ignored: assert property (@(posedge clock) disable iff (!rst_b)
        state.busy && trig_rise && !sck_rise |=> state.step == $past(state.step))
        else $error("trigger during conversion restarted it");
    a_wake_on_shift: assert property (@(posedge clock) disable iff (!rst_b)
        sck_rise |=> power_state == adsr_pkg::ADSR_ACTIVE)
        else $error("shift rise did not wake");
    a_deep_clears_flag: assert property (@(posedge clock) disable iff (!rst_b)
        power_state == adsr_pkg::ADSR_DEEP_DOWN |-> !state.settled)
        else $error("settled while in deep power-down");
    a_light_after_two: assert property (@(posedge clock) disable iff (!rst_b)
        trig_rise && !sck_rise && state.idle_trigs == 3'h1 |=> power_state == adsr_pkg::ADSR_LIGHT_DOWN)
        else $error("two idle triggers did not enter light power-down");
    a_msb_first: assert property (@(posedge clock) disable iff (!rst_b)
        state.busy && sck_rise && state.step == 5'h02 |=> result_out.data == $past(state.word[RESULT_BITS-1]))
        else $error("first result bit is not the msb");
    a_data_stable: assert property (@(posedge clock) disable iff (!rst_b)
        !sck_rise && !trig_rise |=> $stable(result_out.data))
        else $error("output changed without a shift rise");
endmodule
`default_nettype wire

/* hdl/adsr_pkg.sv */
// Package of constants and carrier types for the serial converter readout
package adsr_pkg;
    localparam int RESULT_BITS = 12;
    localparam int IGNORE_SCK_CYCLES = 14;
    localparam int FLAG_EDGE = 2;
    localparam int LIGHT_DOWN_EDGES = 2;
    localparam int DEEP_DOWN_EDGES = 4;
    localparam int SETTLE_US = 12000;
    localparam int CLOCK_MHZ = 200;
    localparam int SETTLE_CYCLES = SETTLE_US * CLOCK_MHZ;
    localparam logic [3:0] STEP_RESET = 4'h0;

    typedef enum logic [1:0] {
        ADSR_ACTIVE,
        ADSR_LIGHT_DOWN,
        ADSR_DEEP_DOWN
    } adsr_power_type;

    // Input pin image of the three-wire port: trigger and shift clock
    typedef struct packed {
        logic trigger;
        logic shift_clock;
    } adsr_pins_type;

    typedef struct packed {
        logic data;
        logic enable;
    } adsr_out_type;
endpackage

/* hdl/adsr_pin_sync.sv */
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module adsr_pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Pins
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
        logic [WIDTH-1:0] rise;
    } adsr_sync_state_type;

    adsr_sync_state_type state;
    adsr_sync_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.s1 = pin;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        next_state.rise = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (state.s2[i] == state.s3[i]) begin
                next_state.lvl[i] = state.s3[i];
                next_state.rise[i] = state.s3[i] & ~state.lvl[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.lvl;
    assign rise = state.rise;
endmodule
`default_nettype wire

/* dv/adsr_host.sv */
// Host serial port model: drives trigger and shift clock, captures result
`timescale 1ns/1ps
`default_nettype none
module adsr_host (
    // Clock
    input wire logic clock,
    // Device pins
    input wire adsr_pkg::adsr_out_type result_out,
    output adsr_pkg::adsr_pins_type pins,
    // Captured bits
    output logic [12:0] word
);
    initial begin
        pins = '0;
        word = '0;
    end
    task automatic half();
        repeat (4) @(posedge clock);
    endtask
    // One shift period with chosen pin levels, then both low
    task automatic pulse(input logic t, input logic s);
        pins.trigger <= t;
        pins.shift_clock <= s;
        half();
        pins.trigger <= 1'b0;
        pins.shift_clock <= 1'b0;
        half();
    endtask
    // Trigger one shift period wide, data taken on every shift rise
    task automatic frame(input int retrig);
        for (int k = 0; k < 16; k++) begin
            pins.shift_clock <= 1'b1;
            pins.trigger <= (k == 0) || (k == retrig);
            word <= {word[11:0], result_out.enable ? result_out.data : 1'bz};
            half();
            pins.shift_clock <= 1'b0;
            half();
        end
    endtask
endmodule
`default_nettype wire

/* dv/test_adsr_readout.sv */
// Self-checking bench of the serial converter readout
`timescale 1ns/1ps
`default_nettype none
module test_adsr_readout;
    logic clock;
    logic rst_b;
    logic [11:0] sample_code;
    logic bipolar_mode;
    adsr_pkg::adsr_pins_type pins;
    adsr_pkg::adsr_out_type result_out;
    adsr_pkg::adsr_power_type power_state;
    logic [12:0] word;
    int fail_count;
    int samples_checked;
    int cycles;
    adsr_readout #(.RESULT_BITS(12), .SETTLE_CYCLES(200)) adsr_readout_i (.clock(clock), .rst_b(rst_b),
        .pins(pins), .result_out(result_out), .sample_code(sample_code), .bipolar_mode(bipolar_mode),
        .power_state(power_state));
    adsr_host adsr_host_i (.clock(clock), .result_out(result_out), .pins(pins), .word(word));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic idle_tristate();
        adsr_host_i.pulse(1'b0, 1'b1);
        check(13'(result_out.enable), 13'h0000);
    endtask
    task automatic frame_code(input logic [11:0] code, input logic bip);
        sample_code <= code;
        bipolar_mode <= bip;
        @(posedge clock);
        adsr_host_i.frame(99);
        check(word, {1'b1, code ^ {bip, 11'h000}});
        check(13'(result_out.enable), 13'h0001);
    endtask
    task automatic retrigger();
        sample_code <= 12'h5a3;
        bipolar_mode <= 1'b0;
        @(posedge clock);
        fork
            adsr_host_i.frame(6);
            begin
                repeat (20) @(posedge clock);
                sample_code <= 12'h0f0;
            end
        join
        check(word, 13'h15a3);
    endtask
    task automatic power_down();
        repeat (2) adsr_host_i.pulse(1'b1, 1'b0);
        check(13'(power_state), 13'(adsr_pkg::ADSR_LIGHT_DOWN));
        adsr_host_i.pulse(1'b0, 1'b1);
        check(13'(power_state), 13'(adsr_pkg::ADSR_ACTIVE));
        repeat (4) adsr_host_i.pulse(1'b1, 1'b0);
        check(13'(power_state), 13'(adsr_pkg::ADSR_DEEP_DOWN));
        adsr_host_i.pulse(1'b0, 1'b1);
        check(13'(power_state), 13'(adsr_pkg::ADSR_ACTIVE));
        // Finish the conversion that the first idle trigger started
        repeat (12) adsr_host_i.pulse(1'b0, 1'b1);
        sample_code <= 12'h800;
        bipolar_mode <= 1'b0;
        adsr_host_i.frame(99);
        check(word, 13'h0800);
    endtask
    initial begin
        rst_b = 1'b0;
        sample_code = '0;
        bipolar_mode = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (220) @(posedge clock);
        idle_tristate();
        frame_code(12'hfff, 1'b0);
        frame_code(12'h000, 1'b1);
        frame_code(12'h801, 1'b1);
        retrigger();
        power_down();
        close_out();
    end
endmodule
`default_nettype wire
